/* hw/odf_formatter.sv */
// Output data formatter: format register, software reset, test patterns and coding.
// Assumes samples arrive as offset binary, synchronous to REF_CLK, one per valid cycle.
// Behaviour
// - Bits 7 and 6 of the format register are ignored on write and have no effect.
// - Pattern code 001 forces all output bits low and code 011 forces all high.
// - Code 101 gives a checkerboard and code 111 toggles the whole word every sample.
// - Format bit 2 turns alternate-bit-polarity mode on the output word on or off.
// - Format bit 1 turns the output randomizer on or off.
// - Format bit 0 selects offset binary (0) or two's complement (1).
// - With alternate-bit-polarity on, coding is offset binary whatever bit 0 says.
// - Software reset clears the format register to 00h and the reset bit then clears itself.
`timescale 1ns/100ps
module odf_formatter
  import odf_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire odf_reg_req_t REG_REQ,
  output logic [7:0] REG_RDATA,
  input wire odf_sample_t SAMPLE_IN,
  output odf_sample_t OUT_WORD
);
  logic rst_meta_r;
  logic rst_n;
  logic [7:0] fmt_r, fmt_nxt;
  logic swrst_r, swrst_nxt;
  logic phase_r, phase_nxt;
  logic [7:0] rdata_nxt;
  odf_sample_t out_nxt;
  logic [2:0] pat;
  logic [11:0] coded;

  // Reset release: two flops so the internal reset leaves on a clean edge
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  assign pat = fmt_r[ODF_PAT_HI:ODF_PAT_LO];

  // Register port: a pending soft reset beats a format write in the same cycle
  always_comb begin
    fmt_nxt = fmt_r;
    swrst_nxt = 1'b0;
    rdata_nxt = 8'h00;
    if (swrst_r) begin
      fmt_nxt = ODF_FORMAT_RST;
    end else if (REG_REQ.we && REG_REQ.addr == ODF_ADDR_FORMAT) begin
      fmt_nxt = REG_REQ.wdata & ODF_FMT_WMASK;
    end
    if (REG_REQ.we && REG_REQ.addr == ODF_ADDR_RESET) begin
      swrst_nxt = REG_REQ.wdata[ODF_SWRST_BIT];
    end
    if (REG_REQ.addr == ODF_ADDR_FORMAT) begin
      rdata_nxt = fmt_r;
    end else if (REG_REQ.addr == ODF_ADDR_RESET) begin
      rdata_nxt = {swrst_r, 7'h00};
    end
  end

  // Data path: coding, then randomizer, then alternate polarity; patterns bypass all three
  always_comb begin
    coded = SAMPLE_IN.data;
    if (fmt_r[ODF_TWOS_BIT] && !fmt_r[ODF_ABP_BIT]) begin
      coded = coded ^ ODF_MSB_MASK;
    end
    if (fmt_r[ODF_OUTPUT_SCRAMBLE_ENABLE_BIT]) begin
      coded = {coded[11:1] ^ {11{coded[0]}}, coded[0]};
    end
    if (fmt_r[ODF_ABP_BIT]) begin
      coded = coded ^ ODF_ABP_MASK;
    end
    out_nxt.valid = SAMPLE_IN.valid;
    out_nxt.data = OUT_WORD.data;
    phase_nxt = phase_r;
    if (SAMPLE_IN.valid) begin
      phase_nxt = ~phase_r;
      unique case (pat)
        ODF_PAT_ZERO: out_nxt.data = 12'h000;
        ODF_PAT_ONES: out_nxt.data = 12'hfff;
        ODF_PAT_CHECK: out_nxt.data = phase_r ? ODF_CHK_B : ODF_CHK_A;
        ODF_PAT_ALT: out_nxt.data = phase_r ? ODF_ALT_B : ODF_ALT_A;
        default: out_nxt.data = coded;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      fmt_r <= ODF_FORMAT_RST;
      swrst_r <= 1'b0;
      phase_r <= 1'b0;
      REG_RDATA <= 8'h00;
      OUT_WORD <= '0;
    end else begin
      fmt_r <= fmt_nxt;
      swrst_r <= swrst_nxt;
      phase_r <= phase_nxt;
      REG_RDATA <= rdata_nxt;
      OUT_WORD <= out_nxt;
    end
  end

  a_reserved_ignored: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (REG_REQ.we && REG_REQ.addr == ODF_ADDR_FORMAT && !swrst_r) |=>
      (fmt_r == {2'b00, $past(REG_REQ.wdata[5:0])}))
    else $error("format write not stored with top bits dropped");
  a_zero_pattern: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (SAMPLE_IN.valid && pat == ODF_PAT_ZERO) |=> (OUT_WORD.valid && OUT_WORD.data == 12'h000))
    else $error("zero pattern wrong");
  a_ones_pattern: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (SAMPLE_IN.valid && pat == ODF_PAT_ONES) |=> (OUT_WORD.data == 12'hfff))
    else $error("ones pattern wrong");
  a_checker_toggle: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (SAMPLE_IN.valid && pat == ODF_PAT_CHECK) ##1 (SAMPLE_IN.valid && pat == ODF_PAT_CHECK) |=>
      (OUT_WORD.data == ~$past(OUT_WORD.data) &&
       (OUT_WORD.data == ODF_CHK_A || OUT_WORD.data == ODF_CHK_B)))
    else $error("checkerboard not alternating");
  a_alt_toggle: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (SAMPLE_IN.valid && pat == ODF_PAT_ALT) ##1 (SAMPLE_IN.valid && pat == ODF_PAT_ALT) |=>
      (OUT_WORD.data == ~$past(OUT_WORD.data) &&
       (OUT_WORD.data == ODF_ALT_A || OUT_WORD.data == ODF_ALT_B)))
    else $error("alternating pattern wrong");
  a_abp_forces_ob: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (SAMPLE_IN.valid && pat == ODF_PAT_OFF && fmt_r[2:1] == 2'b10) |=>
      (OUT_WORD.data == ($past(SAMPLE_IN.data) ^ ODF_ABP_MASK)))
    else $error("alternate polarity output wrong");
  a_output_scramble_enable_xor: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (SAMPLE_IN.valid && pat == ODF_PAT_OFF && fmt_r[2:0] == 3'b010) |=>
      (OUT_WORD.data[0] == $past(SAMPLE_IN.data[0]) &&
       OUT_WORD.data[11:1] == ($past(SAMPLE_IN.data[11:1]) ^ {11{$past(SAMPLE_IN.data[0])}})))
    else $error("randomizer output wrong");
  a_twos_coding: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (SAMPLE_IN.valid && pat == ODF_PAT_OFF && fmt_r[2:0] == 3'b001) |=>
      (OUT_WORD.data == ($past(SAMPLE_IN.data) ^ ODF_MSB_MASK)))
    else $error("two's complement coding wrong");
  a_normal_pass: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (SAMPLE_IN.valid && fmt_r[5:0] == 6'h00) |=> (OUT_WORD.data == $past(SAMPLE_IN.data)))
    else $error("plain conversion data not passed");
  a_swreset_clear: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (REG_REQ.we && REG_REQ.addr == ODF_ADDR_RESET && REG_REQ.wdata[7]) |=>
      swrst_r ##1 (fmt_r == ODF_FORMAT_RST && !swrst_r))
    else $error("software reset did not clear and self-clear");

  // Timing of the data path and the pattern phase
  a_valid_delay: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    1'b1 |=> (OUT_WORD.valid == $past(SAMPLE_IN.valid)))
    else $error("output valid not one cycle behind input valid");

  a_word_holds: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (!SAMPLE_IN.valid) |=> $stable(OUT_WORD.data))
    else $error("output word moved without a sample");

  a_phase_toggle: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    SAMPLE_IN.valid |=> (phase_r != $past(phase_r)))
    else $error("pattern phase did not advance on a sample");

  a_phase_hold: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (!SAMPLE_IN.valid) |=> $stable(phase_r))
    else $error("pattern phase moved without a sample");

  a_ones_valid: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (SAMPLE_IN.valid && pat == ODF_PAT_ONES) |=> OUT_WORD.valid)
    else $error("ones pattern word not marked valid");

  // Coding combinations
  a_abp_over_twos: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (SAMPLE_IN.valid && pat == ODF_PAT_OFF && fmt_r[2:0] == 3'b101) |=>
      (OUT_WORD.data == ($past(SAMPLE_IN.data) ^ ODF_ABP_MASK)))
    else $error("two's complement not suppressed by alternate polarity");

  a_output_scramble_enable_abp: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (SAMPLE_IN.valid && pat == ODF_PAT_OFF && fmt_r[2:0] == 3'b110) |=>
      (OUT_WORD.data == ({$past(SAMPLE_IN.data[11:1]) ^ {11{$past(SAMPLE_IN.data[0])}},
                          $past(SAMPLE_IN.data[0])} ^ ODF_ABP_MASK)))
    else $error("randomizer with alternate polarity wrong");

  // Register reads, format writes and the soft reset
  a_format_readback: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (REG_REQ.addr == ODF_ADDR_FORMAT) |=> (REG_RDATA == $past(fmt_r)))
    else $error("format read data wrong");

  a_reset_readback: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (REG_REQ.addr == ODF_ADDR_RESET) |=> (REG_RDATA == {$past(swrst_r), 7'h00}))
    else $error("reset register read data wrong");

  a_other_reads_zero: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (REG_REQ.addr != ODF_ADDR_FORMAT && REG_REQ.addr != ODF_ADDR_RESET) |=> (REG_RDATA == 8'h00))
    else $error("unmapped address read not zero");

  a_swrst_self_clear: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (swrst_r && !(REG_REQ.we && REG_REQ.addr == ODF_ADDR_RESET && REG_REQ.wdata[ODF_SWRST_BIT])) |=>
      !swrst_r)
    else $error("reset bit did not clear itself");

  a_swrst_beats_write: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (swrst_r && REG_REQ.we && REG_REQ.addr == ODF_ADDR_FORMAT) |=> (fmt_r == ODF_FORMAT_RST))
    else $error("format write survived a pending soft reset");

  a_top_bits_clear: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (REG_REQ.we && REG_REQ.addr == ODF_ADDR_FORMAT) |=> (fmt_r[7:6] == 2'b00))
    else $error("unused format bits were stored");

endmodule : odf_formatter

/* shared/odf_pkg.sv */
// Constants and carrier types for the output data formatter.
// Assumes one 250 MHz clock and a byte-wide register port.
package odf_pkg;
  localparam int unsigned ODF_DW = 12;
  localparam logic [7:0] ODF_ADDR_RESET = 8'h00;
  localparam logic [7:0] ODF_ADDR_FORMAT = 8'h04;
  localparam logic [7:0] ODF_FORMAT_RST = 8'h00;
  localparam int unsigned ODF_SWRST_BIT = 7;
  localparam int unsigned ODF_PAT_HI = 5;
  localparam int unsigned ODF_PAT_LO = 3;
  localparam int unsigned ODF_ABP_BIT = 2;
  localparam int unsigned ODF_OUTPUT_SCRAMBLE_ENABLE_BIT = 1;
  localparam int unsigned ODF_TWOS_BIT = 0;
  localparam logic [7:0] ODF_FMT_WMASK = 8'h3f;
  localparam logic [2:0] ODF_PAT_OFF = 3'h0;
  localparam logic [2:0] ODF_PAT_ZERO = 3'h1;
  localparam logic [2:0] ODF_PAT_ONES = 3'h3;
  localparam logic [2:0] ODF_PAT_CHECK = 3'h5;
  localparam logic [2:0] ODF_PAT_ALT = 3'h7;
  localparam logic [11:0] ODF_CHK_A = 12'haaa;
  localparam logic [11:0] ODF_CHK_B = 12'h555;
  localparam logic [11:0] ODF_ALT_A = 12'h000;
  localparam logic [11:0] ODF_ALT_B = 12'hfff;
  localparam logic [11:0] ODF_MSB_MASK = 12'h800;
  localparam logic [11:0] ODF_ABP_MASK = 12'haaa;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } odf_reg_req_t;

  typedef struct packed {
    logic valid;
    logic [11:0] data;
  } odf_sample_t;
endpackage : odf_pkg

/* bench/odf_capture.sv */
// Downstream capture logic that sits on the formatter's output word.
// Assumes the formatter's REF_CLK and registered OUT_WORD.
`timescale 1ns/100ps
module odf_capture
  import odf_pkg::*;
(
  input wire logic clk,
  input wire odf_sample_t word,
  output logic [11:0] last_word
);
  // Latches each valid word, as a receiving register would
  always @(posedge clk) begin
    if (word.valid) begin
      last_word <= word.data;
    end
  end
endmodule : odf_capture

/* bench/odf_formatter_tb.sv */
// Self-checking bench for the output data formatter.
// Assumes the package constants and a 250 MHz REF_CLK.
`timescale 1ns/100ps
module odf_formatter_tb;
  import odf_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  odf_reg_req_t req = '0;
  odf_sample_t smp = '0;
  logic [7:0] rdata;
  odf_sample_t ow;
  logic [11:0] cap_word;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  bit ph = 1'b0;
  logic [7:0] fmt;
  logic [11:0] last_exp;
  odf_formatter DUT (.REF_CLK(clk), .RESET_N(rst_n), .REG_REQ(req), .REG_RDATA(rdata), .SAMPLE_IN(smp), .OUT_WORD(ow));
  odf_capture cap (.clk(clk), .word(ow), .last_word(cap_word));
  initial forever #2 clk = ~clk;
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    cycles++;
    if (cycles > 2000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic check(logic [11:0] seen, logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(negedge clk) req = '{1'b1, a, v};
    @(negedge clk) req.we = 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(negedge clk) req.addr = a;
    @(negedge clk) check({4'h0, rdata}, {4'h0, e});
  endtask : rd
  function automatic logic [11:0] expect_word(logic [7:0] m, logic [11:0] s, bit p);
    logic [11:0] w;
    w = s;
    case (m[5:3])
      ODF_PAT_ZERO: w = 12'h000;
      ODF_PAT_ONES: w = 12'hfff;
      ODF_PAT_CHECK: w = p ? ODF_CHK_B : ODF_CHK_A;
      ODF_PAT_ALT: w = p ? ODF_ALT_B : ODF_ALT_A;
      default: begin
        if (m[0] && !m[2]) w = w ^ 12'h800;
        if (m[1]) w[11:1] = w[11:1] ^ {11{w[0]}};
        if (m[2]) w = w ^ 12'haaa;
      end
    endcase
    return w;
  endfunction : expect_word
  task automatic send(logic [7:0] m);
    logic [11:0] d;
    d = 12'($urandom);
    @(negedge clk) smp = '{1'b1, d};
    @(negedge clk) smp.valid = 1'b0;
    last_exp = expect_word(m, d, ph);
    check({11'h000, ow.valid}, 12'h001);
    check(ow.data, last_exp);
    ph = ~ph;
  endtask : send
  initial begin
    void'($urandom(32'h0985_7104));
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    for (int i = 0; i < 40; i++) begin
      fmt = 8'($urandom);
      if (i < 8) fmt[5:3] = i[2:0];
      wr(ODF_ADDR_FORMAT, fmt);
      rd(ODF_ADDR_FORMAT, fmt & ODF_FMT_WMASK);
      repeat (3) send(fmt);
    end
    @(negedge clk) req = '{1'b1, ODF_ADDR_RESET, 8'h80};
    @(negedge clk) req = '{1'b1, ODF_ADDR_FORMAT, 8'h3f};
    @(negedge clk) req.we = 1'b0;
    rd(ODF_ADDR_FORMAT, ODF_FORMAT_RST);
    rd(ODF_ADDR_RESET, 8'h00);
    rd(8'h3c, 8'h00);
    send(8'h00);
    @(negedge clk) check(cap_word, last_exp);
    close_out();
  end
endmodule : odf_formatter_tb
